/* File: core/flr_top.sv */
// Fault log, open-drain drive bits and measurement result registers.
// Assumes the serial interface logic issues single-cycle read/write strobes
// on an 8-bit register port, and the converter gives one valid pulse per
// finished conversion. All inputs except rst_n are synchronous to clk.
`timescale 1ns/100ps
// Contract
// RULE_01: Bit 7 pulls pin C low; resets 1.
// RULE_02: Bit 6 pulls pin B low; resets 0.
// RULE_03: Sense above 1 mV, transistor off: bit 5.
// RULE_04: Enable input level change sets bit 4.
// RULE_05: Power-good feedback low sets bit 3.
// RULE_06: Undervoltage input falling sets bit 1.
// RULE_07: Overvoltage input rising sets bit 0.
// RULE_08: Sense result 8 bits, 151 uV steps.
// RULE_09: Output voltage result 8 bits, 60.5 mV.
// RULE_10: Aux input result 8 bits, 4.82 mV.
// RULE_11: Overcurrent trip sets bit 2, held.
// RULE_12: No repeat alert until bit cleared.
// RULE_13: Overvoltage alert only when enabled; enable resets 0.
// RULE_14: Results refresh on every finished conversion.
module flr_top
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic overvoltage_input,
  input wire logic undervoltage_input,
  input wire logic power_good_feedback,
  input wire logic cardEnableN,
  input wire logic overcurrentTrip,
  input wire logic pass_transistorOn,
  input wire logic [7:0] adcShuntCode,
  input wire logic adcShuntValid,
  input wire logic [7:0] adcOutvCode,
  input wire logic adcOutvValid,
  input wire logic [7:0] adcAuxCode,
  input wire logic adcAuxValid,
  input wire logic [5:0] alertEnable,
  input wire logic alertAck,
  output logic alertReq,
  input wire logic open_drain_out_cIn,
  output logic open_drain_out_cOut,
  output logic open_drain_out_cOe,
  input wire logic open_drain_out_bIn,
  output logic open_drain_out_bOut,
  output logic open_drain_out_bOe
);

  logic rstMeta_reg; // Reset synchroniser, first stage
  logic rstSyncN_reg; // Reset synchroniser, second stage
  logic [7:0] faultLog_reg; // Fault log and drive bits
  logic [7:0] faultLog_next;
  logic [7:0] shuntRes_reg; // Sense voltage result
  logic [7:0] outvRes_reg; // Output voltage result
  logic [7:0] auxRes_reg; // Aux input result
  logic overvPrev_reg; // Overvoltage input one cycle ago
  logic undervPrev_reg; // Undervoltage input one cycle ago
  logic enPrev_reg; // Enable input one cycle ago
  logic [5:0] faultEvt; // Set requests for fault bits
  logic wrFault; // Host write to the fault log
  logic pinsSeen; // Pin readbacks, only to keep them loaded

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_reg <= 1'b0;
      rstSyncN_reg <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSyncN_reg <= rstMeta_reg;
    end
  end

  // Previous input levels for edge detection
  always_ff @(posedge clk or negedge rstSyncN_reg)
  begin
    if (!rstSyncN_reg)
    begin
      // Idle levels, so no false edge right after reset
      overvPrev_reg <= 1'b0;
      undervPrev_reg <= 1'b1;
      enPrev_reg <= 1'b1;
    end
    else
    begin
      overvPrev_reg <= overvoltage_input;
      undervPrev_reg <= undervoltage_input;
      enPrev_reg <= cardEnableN;
    end
  end

  // Fault events, one per fault bit 5:0; drive bits 7:6 have none
  always_comb
  begin
    faultEvt = 6'h00;
    faultEvt[flr_pkg::OVER_V_BIT] = overvoltage_input && !overvPrev_reg; // RULE_07
    faultEvt[flr_pkg::UNDER_V_BIT] = undervPrev_reg && !undervoltage_input; // RULE_06
    faultEvt[flr_pkg::OVER_I_BIT] = overcurrentTrip; // RULE_11
    // Level, so a feedback that stays low keeps re-setting a cleared bit
    faultEvt[flr_pkg::POWER_BAD_BIT] = !power_good_feedback; // RULE_05
    faultEvt[flr_pkg::ENABLE_CHG_BIT] = cardEnableN != enPrev_reg; // RULE_04
    // Judged on the latest stored sense result, not raw converter data
    faultEvt[flr_pkg::SHORT_BIT] =
      !pass_transistorOn && (shuntRes_reg > flr_pkg::SHORT_CODE_MAX); // RULE_03
  end

  assign wrFault = regWrEn && (regAddr == flr_pkg::FAULT_LOG_OFFS);

  // Next fault log: host write replaces, events always win
  always_comb
  begin
    faultLog_next = faultLog_reg;
    if (wrFault)
      faultLog_next = regWrData; // RULE_01 RULE_02
    // Set beats a same-cycle clear, so no fault is lost
    faultLog_next[5:0] = faultLog_next[5:0] | faultEvt; // RULE_11
  end

  // Fault log register
  always_ff @(posedge clk or negedge rstSyncN_reg)
  begin
    if (!rstSyncN_reg)
      faultLog_reg <= flr_pkg::FAULT_LOG_RESET; // RULE_01 RULE_02
    else
      faultLog_reg <= faultLog_next;
  end

  // Open-drain pins: drive low only while the bit is set
  assign open_drain_out_cOut = 1'b0;
  assign open_drain_out_cOe = faultLog_reg[flr_pkg::OD_C_BIT]; // RULE_01
  assign open_drain_out_bOut = 1'b0;
  assign open_drain_out_bOe = faultLog_reg[flr_pkg::OD_B_BIT]; // RULE_02
  // Pin levels are reported by the status slice, not here
  assign pinsSeen = open_drain_out_cIn ^ open_drain_out_bIn;

  // Sense result; a conversion wins over a host write
  always_ff @(posedge clk or negedge rstSyncN_reg)
  begin
    if (!rstSyncN_reg)
      shuntRes_reg <= flr_pkg::RESULT_RESET;
    else if (adcShuntValid)
      shuntRes_reg <= adcShuntCode; // RULE_08 RULE_14
    else if (regWrEn && (regAddr == flr_pkg::SHUNT_RES_OFFS))
      shuntRes_reg <= regWrData;
  end

  // Output voltage result
  always_ff @(posedge clk or negedge rstSyncN_reg)
  begin
    if (!rstSyncN_reg)
      outvRes_reg <= flr_pkg::RESULT_RESET;
    else if (adcOutvValid)
      outvRes_reg <= adcOutvCode; // RULE_09 RULE_14
    else if (regWrEn && (regAddr == flr_pkg::OUTV_RES_OFFS))
      outvRes_reg <= regWrData;
  end

  // Aux input result
  always_ff @(posedge clk or negedge rstSyncN_reg)
  begin
    if (!rstSyncN_reg)
      auxRes_reg <= flr_pkg::RESULT_RESET;
    else if (adcAuxValid)
      auxRes_reg <= adcAuxCode; // RULE_10 RULE_14
    else if (regWrEn && (regAddr == flr_pkg::AUX_RES_OFFS))
      auxRes_reg <= regWrData;
  end

  // Read data, registered; reads have no side effects
  always_ff @(posedge clk or negedge rstSyncN_reg)
  begin
    if (!rstSyncN_reg)
      regRdData <= flr_pkg::UNMAPPED_READ;
    else if (regRdEn)
    begin
      unique case (regAddr)
        flr_pkg::FAULT_LOG_OFFS: regRdData <= faultLog_reg;
        flr_pkg::SHUNT_RES_OFFS: regRdData <= shuntRes_reg;
        flr_pkg::OUTV_RES_OFFS: regRdData <= outvRes_reg;
        flr_pkg::AUX_RES_OFFS: regRdData <= auxRes_reg;
        // Other slices answer elsewhere; this one returns zero
        default: regRdData <= flr_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // One alert per fresh fault, gated by the enables
  flr_alert_gen u_alert
  (
    .clk(clk),
    .rstSyncN(rstSyncN_reg),
    .faultBits(faultLog_reg[5:0]),
    .alertEnable(alertEnable),
    .alertAck(alertAck),
    .alertReq(alertReq)
  );

  property p_od_c;
    @(posedge clk) disable iff (!rstSyncN_reg)
    wrFault |=> (open_drain_out_cOe == $past(regWrData[7])) && !open_drain_out_cOut;
  endproperty
  a_od_c: assert property (p_od_c) else $error("Pin C drive mismatch"); // RULE_01

  property p_od_b;
    @(posedge clk) disable iff (!rstSyncN_reg)
    wrFault |=> (open_drain_out_bOe == $past(regWrData[6])) && !open_drain_out_bOut;
  endproperty
  a_od_b: assert property (p_od_b) else $error("Pin B drive mismatch"); // RULE_02

  property p_short;
    @(posedge clk) disable iff (!rstSyncN_reg)
    (!pass_transistorOn && (shuntRes_reg > flr_pkg::SHORT_CODE_MAX)) |=> faultLog_reg[5];
  endproperty
  a_short: assert property (p_short) else $error("Short not logged"); // RULE_03

  property p_en_chg;
    @(posedge clk) disable iff (!rstSyncN_reg)
    (cardEnableN != enPrev_reg) |=> faultLog_reg[4];
  endproperty
  a_en_chg: assert property (p_en_chg) else $error("Enable change not logged"); // RULE_04

  property p_pbad;
    @(posedge clk) disable iff (!rstSyncN_reg)
    !power_good_feedback |=> faultLog_reg[3];
  endproperty
  a_pbad: assert property (p_pbad) else $error("Power bad not logged"); // RULE_05

  property p_underv;
    @(posedge clk) disable iff (!rstSyncN_reg)
    (undervPrev_reg && !undervoltage_input) |=> faultLog_reg[1];
  endproperty
  a_underv: assert property (p_underv) else $error("Undervoltage not logged"); // RULE_06

  property p_overv;
    @(posedge clk) disable iff (!rstSyncN_reg)
    (overvoltage_input && !overvPrev_reg) |=> faultLog_reg[0];
  endproperty
  a_overv: assert property (p_overv) else $error("Overvoltage not logged"); // RULE_07

  property p_oc_hold;
    @(posedge clk) disable iff (!rstSyncN_reg)
    (faultLog_reg[2] && !wrFault) |=> faultLog_reg[2];
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("Overcurrent bit lost"); // RULE_11

  property p_refresh;
    @(posedge clk) disable iff (!rstSyncN_reg)
    adcOutvValid |=> (outvRes_reg == $past(adcOutvCode));
  endproperty
  a_refresh: assert property (p_refresh) else $error("Result not refreshed"); // RULE_09 RULE_14

endmodule

/* File: core/flr_pkg.sv */
// Constants for the fault log and measurement result register slice.
// Assumes an 8-bit register port driven by the serial interface logic.
package flr_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] FAULT_LOG_OFFS = 8'h03;
  localparam logic [7:0] SHUNT_RES_OFFS = 8'h04;
  localparam logic [7:0] OUTV_RES_OFFS = 8'h05;
  localparam logic [7:0] AUX_RES_OFFS = 8'h06;

  // Fault log bit positions
  localparam int OVER_V_BIT = 0;
  localparam int UNDER_V_BIT = 1;
  localparam int OVER_I_BIT = 2;
  localparam int POWER_BAD_BIT = 3;
  localparam int ENABLE_CHG_BIT = 4;
  localparam int SHORT_BIT = 5;
  localparam int OD_B_BIT = 6;
  localparam int OD_C_BIT = 7;
  localparam int FAULT_BITS = 6;

  // Values after reset
  localparam logic [7:0] FAULT_LOG_RESET = 8'h80;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Measurement scaling, for software: LSB and full scale per result
  localparam int SHUNT_LSB_NV = 151000;
  localparam int SHUNT_FULL_UV = 38450;
  localparam int OUTV_LSB_UV = 60500;
  localparam int OUTV_FULL_MV = 15440;
  localparam int AUX_LSB_UV = 4820;
  localparam int AUX_FULL_MV = 1230;

  // Shorted pass transistor threshold: sense voltage above 1 mV
  localparam int SHORT_LIMIT_NV = 1000000;
  localparam logic [7:0] SHORT_CODE_MAX = 8'(SHORT_LIMIT_NV / SHUNT_LSB_NV);

endpackage

/* File: core/flr_alert_gen.sv */
// Alert generator: one pending flag per logged fault, gated by enables.
// Assumes fault bits come straight from the fault log flip-flops.
`timescale 1ns/100ps
module flr_alert_gen
(
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic [5:0] faultBits,
  input wire logic [5:0] alertEnable,
  input wire logic alertAck,
  output logic alertReq
);

  logic [5:0] faultPrev_reg; // Fault bits one cycle ago
  logic [5:0] pend_reg; // Alert pending per fault
  logic [5:0] riseHit; // Fresh, enabled fault per bit

  // Remember last fault state to see fresh faults only
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      faultPrev_reg <= 6'h00;
    else
      faultPrev_reg <= faultBits;
  end

  // Per-bit pending flags; a fresh fault beats an acknowledge
  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_pend
      // A still-set fault bit cannot re-alert until it is cleared
      assign riseHit[i] = faultBits[i] && !faultPrev_reg[i] && alertEnable[i]; // RULE_12 RULE_13
      always_ff @(posedge clk or negedge rstSyncN)
      begin
        if (!rstSyncN)
          pend_reg[i] <= 1'b0;
        else if (riseHit[i])
          pend_reg[i] <= 1'b1;
        else if (alertAck)
          pend_reg[i] <= 1'b0;
      end
    end
  endgenerate

  // Handshake output, combinational from the flags
  assign alertReq = |pend_reg;

  property p_overv_alert;
    @(posedge clk) disable iff (!rstSyncN)
    (faultBits[0] && !faultPrev_reg[0] && alertEnable[0]) |=> alertReq;
  endproperty
  a_overv_alert: assert property (p_overv_alert) else $error("Overvoltage alert missing"); // RULE_13

  property p_overv_masked;
    @(posedge clk) disable iff (!rstSyncN)
    (!alertReq && !alertEnable[0] && faultBits[0] && (riseHit[5:1] == 5'h00)) |=> !alertReq;
  endproperty
  a_overv_masked: assert property (p_overv_masked) else $error("Masked fault raised alert"); // RULE_13

  property p_no_rearm;
    @(posedge clk) disable iff (!rstSyncN)
    (!alertReq && (faultBits == faultPrev_reg)) |=> !alertReq;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("Alert without fresh fault"); // RULE_12

endmodule

/* File: tb/flr_host_model.sv */
// Host model: drives the register port with one-cycle strobes.
// Assumes the shared clk; read data is taken once it has settled.
`timescale 1ns/100ps
module flr_host_model
(
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn
);
  // Idle port from time zero
  initial
  begin
    regAddr = 8'hFF;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // Single write; data inverted after release so no stale value lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask

  // Single read; sampled a cycle late since the data stands until next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    #1;
    d = regRdData;
  endtask
endmodule

/* File: tb/fault_log_and_adc_results_bench.sv */
// Bench: register accesses, fault events, conversions and alert handshake.
// Assumes flr_top and the host model; pins are pulled up outside.
`timescale 1ns/100ps
module fault_log_and_adc_results_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  // Idle levels keep events quiet
  logic overV = 1'b0;
  logic underV = 1'b1;
  logic pwrGood = 1'b1;
  logic enN = 1'b1;
  logic oc = 1'b0;
  logic pon = 1'b1;
  logic [7:0] code = 8'h00;
  logic [2:0] vld = 3'h0;
  logic [5:0] aen = 6'h00;
  logic ack = 1'b0;
  logic [7:0] addr, wd, rdd;
  logic we, re, aReq, cOut, cOe, bOut, bOe;
  int mismatches = 0;
  int num_checks = 0;
  int i;
  logic [7:0] t [4] = '{8'h40, 8'hC0, 8'h00, 8'h80};
  // Pull-ups on both open-drain pins
  wire logic cPin = cOe ? 1'b0 : 1'b1;
  wire logic bPin = bOe ? 1'b0 : 1'b1;
  wire logic [7:0] pins = {4'h0, cOut, bOut, cOe, bOe};

  always #5 clk = ~clk;

  flr_host_model host_u (.clk(clk), .regRdData(rdd), .regAddr(addr), .regWrEn(we),
    .regWrData(wd), .regRdEn(re));

  flr_top dut_u (.clk(clk), .rst_n(rst_n), .regAddr(addr), .regWrEn(we),
    .regWrData(wd), .regRdEn(re), .regRdData(rdd), .overvoltage_input(overV),
    .undervoltage_input(underV), .power_good_feedback(pwrGood), .cardEnableN(enN),
    .overcurrentTrip(oc), .pass_transistorOn(pon), .adcShuntCode(code),
    .adcShuntValid(vld[0]), .adcOutvCode(code), .adcOutvValid(vld[1]),
    .adcAuxCode(code), .adcAuxValid(vld[2]), .alertEnable(aen), .alertAck(ack),
    .alertReq(aReq), .open_drain_out_cIn(cPin), .open_drain_out_cOut(cOut),
    .open_drain_out_cOe(cOe), .open_drain_out_bIn(bPin),
    .open_drain_out_bOut(bOut), .open_drain_out_bOe(bOe));

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e, m);
  endtask

  // One converter pulse on channel k
  task automatic conv(input int k, input logic [7:0] c);
    @(posedge clk);
    code <= c;
    vld <= 3'(1 << k);
    @(posedge clk);
    vld <= 3'h0;
  endtask

  // One-cycle fault event, then back to idle (enable input stays toggled)
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: overV <= 1'b1;
      1: underV <= 1'b0;
      2: oc <= 1'b1;
      3: pwrGood <= 1'b0;
      4: enN <= ~enN;
      default: pon <= 1'b0;
    endcase
    @(posedge clk);
    overV <= 1'b0;
    underV <= 1'b1;
    oc <= 1'b0;
    pwrGood <= 1'b1;
    pon <= 1'b1;
  endtask

  // Bounded watch of the alert line; a missed alert ends the run
  task automatic waital(input logic e, input string m);
    logic s;
    s = 1'b0;
    for (int n = 0; n < 6; n++)
    begin
      @(posedge clk);
      #1;
      if (aReq === 1'b1)
        s = 1'b1;
    end
    chk({7'h0, s}, {7'h0, e}, m);
    if (e && !s)
      test_done();
  endtask

  task automatic ackp;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask

  // Hang guard
  initial
  begin
    #500000;
    mismatches++;
    $display("[ERR] %0t run timed out", $time);
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pins, 8'h02, "pins after reset");
    rdc(flr_pkg::FAULT_LOG_OFFS, flr_pkg::FAULT_LOG_RESET, "log reset");
    for (i = 0; i < 3; i++)
      rdc(8'h04 + 8'(i), flr_pkg::RESULT_RESET, "result reset");
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      host_u.wr(8'h03, t[i]);
      @(posedge clk);
      #1;
      chk(pins, {6'h00, t[i][7], t[i][6]}, "pin drive");
      rdc(8'h03, t[i], "log readback");
    end
    $display("test pins done");
    for (i = 0; i < 3; i++)
      conv(i, 8'hF0 + 8'(i));
    for (i = 0; i < 3; i++)
      rdc(8'h04 + 8'(i), 8'hF0 + 8'(i), "result");
    conv(2, 8'hFF);
    rdc(8'h06, 8'hFF, "refresh");
    // Host writes to every result register, none racing a conversion
    for (i = 0; i < 3; i++)
    begin
      host_u.wr(8'h04 + 8'(i), 8'h3C + 8'(i));
      rdc(8'h04 + 8'(i), 8'h3C + 8'(i), "result write");
    end
    host_u.wr(8'h07, 8'h55);
    rdc(8'h07, flr_pkg::UNMAPPED_READ, "unmapped");
    $display("test results done");
    conv(0, 8'h07);
    host_u.wr(8'h03, 8'h00);
    for (i = 0; i < 6; i++)
    begin
      ev(i);
      repeat (2) @(posedge clk);
      rdc(8'h03, 8'(1 << i), "event bit");
      host_u.wr(8'h03, 8'h00);
    end
    chk({7'h0, aReq}, 8'h00, "alert while disabled");
    conv(0, 8'h06);
    ev(5);
    rdc(8'h03, 8'h00, "short at 06");
    $display("test events done");
    conv(0, 8'h07);
    for (i = 0; i < 6; i++)
    begin
      host_u.wr(8'h03, 8'h00);
      aen <= 6'(1 << i);
      ev(i);
      waital(1'b1, "alert raised");
      ackp();
    end
    // Bit 0 is clear here, so the first event must alert
    aen <= 6'h01;
    ev(0);
    waital(1'b1, "first alert");
    ackp();
    waital(1'b0, "alert after ack");
    // Bit 0 still set: a second event must stay silent
    ev(0);
    waital(1'b0, "no repeat alert");
    host_u.wr(8'h03, 8'h00);
    ev(0);
    waital(1'b1, "alert after clear");
    ackp();
    aen <= 6'h00;
    host_u.wr(8'h03, 8'h00);
    ev(0);
    waital(1'b0, "alert disabled");
    $display("test alert done");
    test_done();
  end
endmodule
